// ### bench/extended_system_control_props.sv
// assertions for the extended control register bank
// assumes the top module ports; bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module ext_ctrl_props (
  input wire logic pclk, // bus clock
  input wire logic presetn, // system reset
  input wire logic [31:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic lockup_in, // lock-up level
  input wire logic sys_reset_req, // reset request
  input wire logic core_voltage_boost, // boost select
  input wire logic amp_enable, // amp on
  input wire logic amp_neg_input_select, // neg channel
  input wire logic amp_pos_input_select // pos channel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed accesses to the control word
  logic acc;
  logic wr;
  assign acc = psel && penable && pready && paddr == ext_ctrl_pkg::EXT_CTRL_ADDR;
  assign wr = acc && pwrite;
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  AST_CTRL_READ: assert property (acc && !pwrite |-> prdata[31:19] == 13'h0 &&
    prdata[18:8] == {amp_pos_input_select, amp_neg_input_select, amp_enable,
    5'h01, core_voltage_boost, 2'h2} && prdata[5:0] == 6'h0)
    else $error("control word read mismatch");
  AST_BOOST_WR: assert property (wr && pstrb[1] |=> core_voltage_boost == $past(pwdata[10]))
    else $error("boost output not written");
  AST_AMP_WR: assert property (wr && pstrb[2] |=>
    {amp_pos_input_select, amp_neg_input_select, amp_enable} == $past(pwdata[18:16]))
    else $error("amplifier outputs not written");
  // outputs only move on a write
  AST_HOLD: assert property (!(psel && penable && pwrite) |=>
    $stable({amp_pos_input_select, amp_neg_input_select, amp_enable, core_voltage_boost}))
    else $error("control output moved without write");
  AST_UNMAPPED: assert property (psel && penable && pready && pslverr |-> prdata == 32'h0)
    else $error("error access returned data");
  AST_REQ_CAUSE: assert property ($rose(sys_reset_req) |-> $past(lockup_in) &&
    !$past(lockup_in, 2)) else $error("reset request without lock-up edge");
  AST_REQ_LEN: assert property ($rose(sys_reset_req) |->
    sys_reset_req [*8] ##1 !sys_reset_req) else $error("reset request length wrong");
  // main scenarios reached
  COV_WR: cover property (wr);
  COV_REQ: cover property ($rose(sys_reset_req));
  COV_ERR: cover property (pslverr && pready);
endmodule : ext_ctrl_props
bind extended_system_control ext_ctrl_props ext_ctrl_props_i (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lockup_in(lockup_in),
  .sys_reset_req(sys_reset_req), .core_voltage_boost(core_voltage_boost),
  .amp_enable(amp_enable), .amp_neg_input_select(amp_neg_input_select),
  .amp_pos_input_select(amp_pos_input_select));
`default_nettype wire

// ### bench/tb_extended_system_control.sv
// self-checking bench for the extended control register bank
// assumes the design package is compiled first; the bench is the apb master
`timescale 1ns/100ps
`default_nettype none
module tb_extended_system_control;
  localparam logic [31:0] CTRL = ext_ctrl_pkg::EXT_CTRL_ADDR;
  localparam logic [31:0] STS = ext_ctrl_pkg::IRQ_STATUS_ADDR;
  localparam logic [31:0] MSK = ext_ctrl_pkg::IRQ_MASK_ADDR;
  localparam logic [31:0] CNT = ext_ctrl_pkg::LOCKUP_COUNT_ADDR;
  logic pclk, presetn, por_n, psel, penable, pwrite, lockup_in, pready, pslverr, err;
  logic sys_reset_req, core_voltage_boost, amp_enable, nsel, psl, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  int miscompares = 0;
  int n_checks = 0;
  extended_system_control extended_system_control_i (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lockup_in(lockup_in), .sys_reset_req(sys_reset_req),
    .core_voltage_boost(core_voltage_boost), .amp_enable(amp_enable),
    .amp_neg_input_select(nsel), .amp_pos_input_select(psl), .irq(irq));
  // free running bus clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; ends at a falling edge so register updates have landed
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task automatic t_reset();
    rchk(CTRL, 32'h0000_0a00);
    rchk(STS, 32'h0);
    rchk(MSK, 32'h0);
    apb(1'b0, 32'h4002_3810, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset
  // each boost and amplifier field alone, output and read back
  task automatic t_fields();
    int b[4] = '{10, 16, 17, 18};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL, 32'h1 << b[i]);
      chk({28'h0, psl, nsel, amp_enable, core_voltage_boost}, 32'h1 << i);
      rchk(CTRL, 32'h0a00 | (32'h1 << b[i]));
    end
    apb(1'b1, CTRL, 32'h0);
  endtask : t_fields
  // lock-up with the monitor off: only the ignored event, masked irq
  task automatic t_lockup_off();
    @(posedge pclk);
    lockup_in <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, sys_reset_req}, 32'h0);
    rchk(CTRL, 32'h0a00);
    rchk(STS, 32'h1);
    rchk(CNT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, MSK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    lockup_in <= 1'b0;
  endtask : t_lockup_off
  // enabled lock-up, flag through the reset it caused
  task automatic t_lockup_on();
    apb(1'b1, CTRL, 32'h40);
    @(posedge pclk);
    lockup_in <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, sys_reset_req}, 32'h1);
    rchk(CTRL, 32'h0ac0);
    rchk(CNT, 32'h2);
    repeat (10) @(posedge pclk);
    chk({31'h0, sys_reset_req}, 32'h0);
    apb(1'b1, CTRL, 32'h40);
    rchk(CTRL, 32'h0ac0);
    @(posedge pclk);
    presetn <= 1'b0;
    lockup_in <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(CTRL, 32'h0a80);
    rchk(STS, 32'h2);
    rchk(CNT, 32'h0);
    apb(1'b1, MSK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, STS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, CTRL, 32'h80);
    rchk(CTRL, 32'h0a00);
  endtask : t_lockup_on
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // hang guard, well above the 130 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    presetn <= 1'b0;
    por_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 32'h0;
    pwdata <= 32'h0;
    pstrb <= 4'hf;
    lockup_in <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_fields();
    t_lockup_off();
    t_lockup_on();
    give_verdict();
  end
endmodule : tb_extended_system_control
`default_nettype wire

// ### verilog/ext_ctrl_pkg.sv
// constants for the extended control register bank
// assumes a 32-bit apb slave at fixed system addresses and a 125 mhz pclk
package ext_ctrl_pkg;

  // register byte addresses
  localparam logic [31:0] EXT_CTRL_ADDR = 32'h4002_3800;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4002_3804;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4002_3808;
  localparam logic [31:0] LOCKUP_COUNT_ADDR = 32'h4002_380c;

  // value read from the control word right after reset while the lock-up flag is clear
  localparam logic [31:0] EXT_CTRL_RESET = 32'h0000_0a00;

  // field positions inside the control word
  localparam int LOCKUP_EN_BIT = 6;
  localparam int LOCKUP_FLAG_BIT = 7;
  localparam int VOLT_BOOST_BIT = 10;
  localparam int AMP_EN_BIT = 16;
  localparam int AMP_NSEL_BIT = 17;
  localparam int AMP_PSEL_BIT = 18;

  // bits carried by flip-flops; everything else is a fixed read value
  localparam logic [31:0] EXT_CTRL_FIELDS = 32'h0007_04c0;
  localparam logic [31:0] EXT_CTRL_FIXED = EXT_CTRL_RESET & ~EXT_CTRL_FIELDS;

  // field reset values
  localparam logic VOLT_BOOST_RST = 1'b0;
  localparam logic AMP_EN_RST = 1'b0;
  localparam logic AMP_NSEL_RST = 1'b0;
  localparam logic AMP_PSEL_RST = 1'b0;
  localparam logic LOCKUP_EN_RST = 1'b0;

  // interrupt status layout (mask register uses the same layout)
  localparam int IRQ_W = 2;
  localparam int IRQ_IGNORED_BIT = 0;
  localparam int IRQ_RESTART_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // lock-up event counter
  localparam int LOCKUP_CNT_W = 8;
  localparam logic [LOCKUP_CNT_W-1:0] LOCKUP_CNT_RST = 8'h00;
  localparam logic [LOCKUP_CNT_W-1:0] LOCKUP_CNT_MAX = 8'hff;

  // system reset request pulse length
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_REQ_NS = 64;
  localparam int RST_REQ_CYCLES = (RST_REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 4;
  localparam logic [RST_CNT_W-1:0] RST_REQ_LOAD = RST_CNT_W'(RST_REQ_CYCLES);
  localparam logic [RST_CNT_W-1:0] RST_CNT_RST = 4'h0;

  // bus slave states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_READY = 1'b1
  } bus_state_t;

endpackage : ext_ctrl_pkg

// ### verilog/extended_system_control.sv
// extended system control register bank with apb slave and interrupt logic
// assumes an apb master on pclk, presetn as system reset, por_n as power-on
// reset, and analog blocks that only take the control levels driven here
`timescale 1ns/100ps
`default_nettype none

module extended_system_control (
  input wire logic pclk, // bus clock, 125 mhz
  input wire logic presetn, // system reset, async, active low
  input wire logic por_n, // power-on reset, async, active low
  input wire logic [31:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb write byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic lockup_in, // core lock-up level
  output logic sys_reset_req, // request for a system reset
  output logic core_voltage_boost, // regulator boost select
  output logic amp_enable, // amplifier on
  output logic amp_neg_input_select, // amplifier negative channel
  output logic amp_pos_input_select, // amplifier positive channel
  output logic irq // level interrupt
);

  // all bus-side state of the bank
  typedef struct packed {
    ext_ctrl_pkg::bus_state_t state;
    logic [31:0] rdata;
    logic err;
    logic volt_boost;
    logic amp_en;
    logic amp_nsel;
    logic amp_psel;
    logic lockup_en;
    logic restart_seen;
    logic [ext_ctrl_pkg::IRQ_W-1:0] status;
    logic [ext_ctrl_pkg::IRQ_W-1:0] mask;
    logic [ext_ctrl_pkg::LOCKUP_CNT_W-1:0] lockup_cnt;
  } regs_t;

  regs_t r;
  regs_t r_nxt;

  // signals shared with the monitor
  logic flag;
  logic flag_clear;
  logic lockup_rise;
  logic ignored_evt;

  // bus phase decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // full 32-bit compare, so aliases of the word do not answer
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] base);
    addr_hit = (addr == base);
  endfunction : addr_hit

  // any mapped register
  function automatic logic addr_mapped(input logic [31:0] addr);
    addr_mapped = addr_hit(addr, ext_ctrl_pkg::EXT_CTRL_ADDR)
                | addr_hit(addr, ext_ctrl_pkg::IRQ_STATUS_ADDR)
                | addr_hit(addr, ext_ctrl_pkg::IRQ_MASK_ADDR)
                | addr_hit(addr, ext_ctrl_pkg::LOCKUP_COUNT_ADDR);
  endfunction : addr_mapped

  // byte-lane merge of write data over the old word
  function automatic logic [31:0] strb_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    strb_merge = (old & ~lane) | (wdata & lane);
  endfunction : strb_merge

  // control word as software sees it
  function automatic logic [31:0] ctrl_word(input regs_t s, input logic f);
    logic [31:0] w;
    w = ext_ctrl_pkg::EXT_CTRL_FIXED;
    w[ext_ctrl_pkg::LOCKUP_EN_BIT] = s.lockup_en;
    w[ext_ctrl_pkg::LOCKUP_FLAG_BIT] = f;
    w[ext_ctrl_pkg::VOLT_BOOST_BIT] = s.volt_boost;
    w[ext_ctrl_pkg::AMP_EN_BIT] = s.amp_en;
    w[ext_ctrl_pkg::AMP_NSEL_BIT] = s.amp_nsel;
    w[ext_ctrl_pkg::AMP_PSEL_BIT] = s.amp_psel;
    ctrl_word = w;
  endfunction : ctrl_word

  // read multiplexer, zero for unmapped addresses
  function automatic logic [31:0] read_mux(
    input logic [31:0] addr,
    input regs_t s,
    input logic f
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (addr_hit(addr, ext_ctrl_pkg::EXT_CTRL_ADDR)) begin
      d = ctrl_word(s, f);
    end else if (addr_hit(addr, ext_ctrl_pkg::IRQ_STATUS_ADDR)) begin
      d[ext_ctrl_pkg::IRQ_W-1:0] = s.status;
    end else if (addr_hit(addr, ext_ctrl_pkg::IRQ_MASK_ADDR)) begin
      d[ext_ctrl_pkg::IRQ_W-1:0] = s.mask;
    end else if (addr_hit(addr, ext_ctrl_pkg::LOCKUP_COUNT_ADDR)) begin
      d[ext_ctrl_pkg::LOCKUP_CNT_W-1:0] = s.lockup_cnt;
    end
    read_mux = d;
  endfunction : read_mux

  // apb phases; the slave always answers in the first access cycle
  assign setup_phase = psel & ~penable;
  assign pready = psel & penable & (r.state == ext_ctrl_pkg::ST_READY);
  assign access_done = pready;
  assign wr_done = access_done & pwrite;

  // write decode, taken only at the completing edge
  assign wr_ctrl = wr_done & addr_hit(paddr, ext_ctrl_pkg::EXT_CTRL_ADDR);
  assign wr_status = wr_done & addr_hit(paddr, ext_ctrl_pkg::IRQ_STATUS_ADDR);
  assign wr_mask = wr_done & addr_hit(paddr, ext_ctrl_pkg::IRQ_MASK_ADDR);

  // one clears the flag, zero is ignored; lane 0 must be strobed
  assign flag_clear = wr_ctrl & pstrb[0] & pwdata[ext_ctrl_pkg::LOCKUP_FLAG_BIT];

  // read data comes straight from flops; the error flop is gated by pready
  assign prdata = r.rdata;
  assign pslverr = pready & r.err;

  // control outputs to regulator and amplifier
  assign core_voltage_boost = r.volt_boost;
  assign amp_enable = r.amp_en;
  assign amp_neg_input_select = r.amp_nsel;
  assign amp_pos_input_select = r.amp_psel;

  // interrupt is high while any unmasked status bit stands
  assign irq = |(r.status & r.mask);

  // flag and reset request live in the power-on domain
  lockup_monitor u_monitor (
    .pclk(pclk),
    .por_n(por_n),
    .lockup_in(lockup_in),
    .enable(r.lockup_en),
    .flag_clear(flag_clear),
    .flag(flag),
    .sys_reset_req(sys_reset_req),
    .lockup_rise(lockup_rise),
    .ignored_evt(ignored_evt)
  );

  // next-state logic for the whole bank
  always_comb begin
    logic [31:0] cw;
    logic [ext_ctrl_pkg::IRQ_W-1:0] evt;
    logic [ext_ctrl_pkg::IRQ_W-1:0] w1c;
    logic [31:0] mw;
    cw = 32'h0000_0000;
    evt = '0;
    w1c = '0;
    mw = 32'h0000_0000;
    r_nxt = r;

    // bus sequencing: read data captured in setup, held until next setup
    unique case (r.state)
      ext_ctrl_pkg::ST_IDLE: begin
        if (setup_phase) begin
          r_nxt.state = ext_ctrl_pkg::ST_READY;
          r_nxt.err = ~addr_mapped(paddr);
          r_nxt.rdata = pwrite ? 32'h0000_0000 : read_mux(paddr, r, flag);
        end
      end
      ext_ctrl_pkg::ST_READY: begin
        if (access_done) begin
          r_nxt.state = ext_ctrl_pkg::ST_IDLE;
        end else if (!psel) begin
          r_nxt.state = ext_ctrl_pkg::ST_IDLE;
        end
      end
    endcase

    // control word write, byte lanes honoured
    if (wr_ctrl) begin
      cw = strb_merge(ctrl_word(r, flag), pwdata, pstrb);
      r_nxt.lockup_en = cw[ext_ctrl_pkg::LOCKUP_EN_BIT];
      r_nxt.volt_boost = cw[ext_ctrl_pkg::VOLT_BOOST_BIT];
      r_nxt.amp_en = cw[ext_ctrl_pkg::AMP_EN_BIT];
      r_nxt.amp_nsel = cw[ext_ctrl_pkg::AMP_NSEL_BIT];
      r_nxt.amp_psel = cw[ext_ctrl_pkg::AMP_PSEL_BIT];
    end

    // mask write
    if (wr_mask) begin
      mw = strb_merge({30'h0, r.mask}, pwdata, pstrb);
      r_nxt.mask = mw[ext_ctrl_pkg::IRQ_W-1:0];
    end

    // events: ignored lock-up, and first cycle after a lock-up restart
    evt[ext_ctrl_pkg::IRQ_IGNORED_BIT] = ignored_evt;
    evt[ext_ctrl_pkg::IRQ_RESTART_BIT] = flag & ~r.restart_seen;
    r_nxt.restart_seen = 1'b1;

    // status: write one clears, a fresh event wins over the clear
    if (wr_status && pstrb[0]) begin
      w1c = pwdata[ext_ctrl_pkg::IRQ_W-1:0];
    end
    r_nxt.status = (r.status & ~w1c) | evt;

    // lock-up counter saturates rather than wraps
    if (lockup_rise && (r.lockup_cnt != ext_ctrl_pkg::LOCKUP_CNT_MAX)) begin
      r_nxt.lockup_cnt = r.lockup_cnt + 8'h01;
    end
  end

  // single register stage; system reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state <= ext_ctrl_pkg::ST_IDLE;
      r.rdata <= 32'h0000_0000;
      r.err <= 1'b0;
      r.volt_boost <= ext_ctrl_pkg::VOLT_BOOST_RST;
      r.amp_en <= ext_ctrl_pkg::AMP_EN_RST;
      r.amp_nsel <= ext_ctrl_pkg::AMP_NSEL_RST;
      r.amp_psel <= ext_ctrl_pkg::AMP_PSEL_RST;
      r.lockup_en <= ext_ctrl_pkg::LOCKUP_EN_RST;
      r.restart_seen <= 1'b0;
      r.status <= ext_ctrl_pkg::IRQ_STATUS_RST;
      r.mask <= ext_ctrl_pkg::IRQ_MASK_RST;
      r.lockup_cnt <= ext_ctrl_pkg::LOCKUP_CNT_RST;
    end else begin
      r <= r_nxt;
    end
  end

endmodule : extended_system_control

`default_nettype wire

// ### verilog/lockup_monitor.sv
// lock-up monitor: edge detect, sticky lock-up flag, reset request stretcher
// assumes lockup_in is synchronous to pclk; por_n is the power-on reset only
`timescale 1ns/100ps
`default_nettype none

module lockup_monitor (
  input wire logic pclk, // bus clock
  input wire logic por_n, // power-on reset, async, active low
  input wire logic lockup_in, // core lock-up level
  input wire logic enable, // monitor enable from control word
  input wire logic flag_clear, // one-cycle clear request
  output logic flag, // sticky lock-up reset flag
  output logic sys_reset_req, // system reset request level
  output logic lockup_rise, // any new lock-up, one cycle
  output logic ignored_evt // lock-up while monitor off, one cycle
);

  typedef struct packed {
    logic lockup_d;
    logic flag;
    logic [ext_ctrl_pkg::RST_CNT_W-1:0] cnt;
  } mon_t;

  mon_t r;
  mon_t r_nxt;

  // only the rising edge counts, so a lock-up held through restart fires once
  assign lockup_rise = lockup_in & ~r.lockup_d;
  assign ignored_evt = lockup_rise & ~enable;
  assign flag = r.flag;
  assign sys_reset_req = (r.cnt != ext_ctrl_pkg::RST_CNT_RST);

  // next state: set beats clear in the same cycle
  always_comb begin
    r_nxt = r;
    r_nxt.lockup_d = lockup_in;
    if (flag_clear) begin
      r_nxt.flag = 1'b0;
    end
    if (lockup_rise && enable) begin
      r_nxt.flag = 1'b1;
      r_nxt.cnt = ext_ctrl_pkg::RST_REQ_LOAD;
    end else if (r.cnt != ext_ctrl_pkg::RST_CNT_RST) begin
      r_nxt.cnt = r.cnt - 4'h1;
    end
  end

  // por only: the flag must live through the system reset it asked for
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

endmodule : lockup_monitor

`default_nettype wire
